// ==== logic/lcd_defs.svh ====
// Function
// R1: sixteen-byte display RAM holds element on/off bits
// R2: RAM scanned automatically in step with commons
// R3: bit one lit waveform, zero unlit
// R4: processor RAM access anytime, never stalls
// R5: select bits hand upper segments to port
// R6: RAM behind port pins is plain memory
// R7: lowest eight segment pins always segments
// R8: upper segments reassigned four pins per bit
// R9: duty selects two, three or four commons
// R10: polarity alternates over two frames, no DC
// R11: unused commons carry non-selected level
// R12: duty zero halts, all outputs low
// R13: reset: dedicated segments low, rest port
// R14: waveforms start once frame clock runs
// R15: frame clock source switchable while running
// R16: software blanks before switching frame clock
// R17: switch off at duty zero or watch stop
// R18: nonzero duty turns drive switch on
// R19: divider_connect connects internal bias divider
// R20: half duty ignores bits 2,3,6,7
// R21: blank forces unlit waveform on all segments
// R22: frame_clock_select zero main, one sub
// R23: run_in_watch_mode keeps display in clock mode
// R24: commons activated ascending, one per slot
// R25: RAM writes visible by next reading slot
`ifndef LCD_DEFS_SVH
`define LCD_DEFS_SVH

// register byte addresses
`define ADDR_RAM_LAST     5'h0f
`define ADDR_CONTROL_0    5'h10
`define ADDR_CONTROL_1    5'h11
`define ADDR_COMMON_SEL   5'h12
`define ADDR_STATUS       5'h13

// lcd_control_0 field positions
`define C0_DUTY_LO        2
`define C0_DUTY_HI        3
`define C0_BLANK          4
`define C0_DIVIDER        5
`define C0_RUN_IN_WATCH   6
`define C0_CLOCK_SEL      7

// duty_select codes
`define DUTY_STOP         2'h0
`define DUTY_HALF         2'h1

// reset values
`define RST_CONTROL_0     8'h00
`define RST_CONTROL_1     8'h00
`define RST_COMMON_SEL    8'h00
`define RST_SEG_ENABLE    32'h000000ff

// drive level codes, V0 is ground
`define LV0               2'h0
`define LV1               2'h1
`define LV2               2'h2
`define LV3               2'h3

// watch_mode_select level that means clock mode
`define CLOCK_MODE_LVL    1'b0

`endif

// ==== logic/lcd_pkg.sv ====
`default_nettype none
package lcd_pkg;

    typedef logic [1:0] level_t;

    typedef enum logic [0:0] {
        ST_STOP,
        ST_RUN
    } scan_state_e;

    typedef struct packed {
        logic       frame_clock_select;
        logic       run_in_watch_mode;
        logic       divider_connect;
        logic       blank_select;
        logic [1:0] duty_select;
        logic [1:0] frame_period;
    } control_0_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

endpackage
`default_nettype wire

// ==== logic/lcd_segment_common_driver.sv ====
// The register offsets and strobed register access are this design's own decisions.
`include "lcd_defs.svh"
`default_nettype none
module lcd_segment_common_driver #(
    parameter int RAM_BYTES = 16
) (
    input  wire logic            ref_clk,           // system clock, 40 MHz
    input  wire logic            rstn,              // async reset, active low
    input  wire lcd_pkg::reg_req_s req,             // register port request
    output logic [7:0]           rdata_q,           // read data, cycle after read
    input  wire logic            main_clk_pin,      // main oscillator frame clock
    input  wire logic            sub_clk_pin,       // sub-clock frame clock
    input  wire logic            watch_mode_select, // low means clock mode
    output logic [3:0][1:0]      com_level_q,       // common drive level codes
    output logic [31:0][1:0]     seg_level_q,       // segment drive level codes
    output logic [3:0]           com_en_q,          // common pin in lcd use
    output logic [31:0]          seg_en_q,          // segment pin in lcd use
    output logic [31:0]          port_in_en_q,      // port input path allowed
    output logic                 drive_switch_q,    // drive-enable transistor on
    output logic                 divider_on_q       // internal bias divider on
);
    import lcd_pkg::*;

    localparam int SEG_PINS = 2 * RAM_BYTES;
    localparam int GROUPS   = (SEG_PINS - 8) / 4;

    if (RAM_BYTES != 16) begin : g_bad_size
        $error("RAM_BYTES must be 16 to match 32 segment pins");
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic level_t com_drive(input logic sel, input logic pol);
        if (sel)
            com_drive = pol ? `LV0 : `LV3;
        else
            com_drive = pol ? `LV2 : `LV1;
    endfunction

    function automatic level_t seg_drive(input logic lit, input logic pol);
        if (lit)
            seg_drive = pol ? `LV3 : `LV0;
        else
            seg_drive = pol ? `LV1 : `LV2;
    endfunction

    // true when a level code is a rail (V0 or V3), used only by checks
    function automatic logic is_rail(input level_t lv);
        is_rail = (lv == `LV0) || (lv == `LV3);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]  ram_q [RAM_BYTES];
    control_0_s  ctrl0_q;
    logic [7:0]  ctrl1_q;
    logic [7:0]  com_sel_q;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < RAM_BYTES; i++)
                ram_q[i] <= 8'h00;
        end
        else if (req.wr && req.addr <= `ADDR_RAM_LAST)
        begin
            ram_q[req.addr[3:0]] <= req.wdata; // [R1] [R4] [R6]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl0_q   <= `RST_CONTROL_0;
            ctrl1_q   <= `RST_CONTROL_1;
            com_sel_q <= `RST_COMMON_SEL;
        end
        else if (req.wr)
        begin
            if (req.addr == `ADDR_CONTROL_0)
                ctrl0_q <= req.wdata;
            else if (req.addr == `ADDR_CONTROL_1)
                ctrl1_q <= {2'h0, req.wdata[5:0]};
            else if (req.addr == `ADDR_COMMON_SEL)
                com_sel_q <= {4'h0, req.wdata[3:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame clock and watch mode synchronisers

    logic [2:0] main_sync_q;
    logic [2:0] sub_sync_q;
    logic [1:0] watch_sync_q;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            main_sync_q  <= 3'h0;
            sub_sync_q   <= 3'h0;
            watch_sync_q <= 2'h3;
        end
        else
        begin
            main_sync_q  <= {main_sync_q[1:0], main_clk_pin};
            sub_sync_q   <= {sub_sync_q[1:0], sub_clk_pin};
            watch_sync_q <= {watch_sync_q[0], watch_mode_select};
        end
    end

    logic main_edge;
    logic sub_edge;
    logic slot_tick;
    logic clock_mode;
    logic watch_stop;
    logic run_c;
    logic [1:0] last_slot;

    // edges taken from the second and third stages only
    assign main_edge  = main_sync_q[1] & ~main_sync_q[2];
    assign sub_edge   = sub_sync_q[1] & ~sub_sync_q[2];
    // source mux sits after the edge detectors so a switch cannot glitch
    assign slot_tick  = ctrl0_q.frame_clock_select ? sub_edge : main_edge; // [R15] [R22]
    assign clock_mode = (watch_sync_q[1] == `CLOCK_MODE_LVL);
    assign watch_stop = clock_mode && !ctrl0_q.run_in_watch_mode; // [R23]
    assign run_c      = (ctrl0_q.duty_select != `DUTY_STOP) && !watch_stop; // [R12]
    assign last_slot  = ctrl0_q.duty_select; // [R9]

    ////////////////////////////////////////////////////////////////////////
    // scan sequencer

    scan_state_e state_q;
    logic [1:0]  slot_q;
    logic        pol_q;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            state_q <= ST_STOP;
        else
        begin
            case (state_q)
                ST_STOP: if (run_c) state_q <= ST_RUN;
                ST_RUN:  if (!run_c) state_q <= ST_STOP;
                default: state_q <= ST_STOP;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            slot_q <= 2'h0;
            pol_q  <= 1'b0;
        end
        else if (!run_c)
        begin
            slot_q <= 2'h0;
            pol_q  <= 1'b0;
        end
        else if (slot_tick) // [R14]
        begin
            if (slot_q >= last_slot)
            begin
                slot_q <= 2'h0;
                pol_q  <= ~pol_q; // [R10]
            end
            else
                slot_q <= slot_q + 2'h1; // [R24]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // drive levels, rebuilt every cycle straight from the RAM

    logic [3:0][1:0]  com_level_d;
    logic [31:0][1:0] seg_level_d;

    always_comb
    begin
        logic [3:0] nib;
        logic       lit;
        nib = 4'h0;
        lit = 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            if (!run_c || !com_en_q[c])
                com_level_d[c] = `LV0; // [R12]
            else if (c > int'(last_slot))
                com_level_d[c] = com_drive(1'b0, pol_q); // [R11]
            else
                com_level_d[c] = com_drive(slot_q == 2'(c), pol_q); // [R24]
        end
        for (int s = 0; s < SEG_PINS; s++)
        begin
            // low nibble feeds the even pin, high nibble the odd pin;
            // slot passes last_slot only after duty is lowered mid-frame, until the next tick resets it; only then are unused bits read
            nib = s[0] ? ram_q[s / 2][7:4] : ram_q[s / 2][3:0]; // [R2] [R20]
            lit = nib[slot_q] && !ctrl0_q.blank_select; // [R3] [R21] [R25]
            if (!run_c || !seg_en_q[s])
                seg_level_d[s] = `LV0; // [R12] [R13]
            else
                seg_level_d[s] = seg_drive(lit, pol_q); // [R3]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            com_level_q <= '0;
            seg_level_q <= '0;
        end
        else
        begin
            com_level_q <= com_level_d;
            seg_level_q <= seg_level_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin sharing and analog switches

    logic [31:0] seg_en_d;

    always_comb
    begin
        seg_en_d = `RST_SEG_ENABLE; // [R7]
        for (int g = 0; g < GROUPS; g++)
            seg_en_d[8 + 4 * g +: 4] = {4{ctrl1_q[g]}}; // [R5] [R8]
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            seg_en_q     <= `RST_SEG_ENABLE; // [R13]
            port_in_en_q <= ~`RST_SEG_ENABLE;
            com_en_q     <= 4'h0;
        end
        else
        begin
            seg_en_q     <= seg_en_d;
            port_in_en_q <= ~seg_en_d; // [R5]
            com_en_q     <= com_sel_q[3:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            drive_switch_q <= 1'b0;
            divider_on_q   <= 1'b0;
        end
        else
        begin
            drive_switch_q <= run_c; // [R17] [R18]
            divider_on_q   <= ctrl0_q.divider_connect; // [R19]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, never waits

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            rdata_q <= 8'h00;
        else if (!req.rd)
            rdata_q <= 8'h00;
        else if (req.addr <= `ADDR_RAM_LAST)
            rdata_q <= ram_q[req.addr[3:0]]; // [R4]
        else if (req.addr == `ADDR_CONTROL_0)
            rdata_q <= ctrl0_q;
        else if (req.addr == `ADDR_CONTROL_1)
            rdata_q <= ctrl1_q;
        else if (req.addr == `ADDR_COMMON_SEL)
            rdata_q <= com_sel_q;
        else if (req.addr == `ADDR_STATUS)
            rdata_q <= {3'h0, clock_mode, state_q == ST_RUN, pol_q, slot_q};
        else
            rdata_q <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic any_seg_rail;

    always_comb
    begin
        any_seg_rail = 1'b0;
        for (int s = 0; s < 32; s++)
            any_seg_rail = any_seg_rail | (is_rail(seg_level_q[s]) && seg_en_q[s]);
    end

    stop_outputs_low_a: assert property ( // [R12]
        @(posedge ref_clk) disable iff (!rstn)
        ctrl0_q.duty_select == `DUTY_STOP |=> com_level_q == '0 && seg_level_q == '0)
        else $error("outputs not low in stop mode");

    switch_off_a: assert property ( // [R17]
        @(posedge ref_clk) disable iff (!rstn)
        (ctrl0_q.duty_select == `DUTY_STOP || watch_stop) |=> !drive_switch_q)
        else $error("drive switch on while stopped");

    switch_on_a: assert property ( // [R18]
        @(posedge ref_clk) disable iff (!rstn)
        (ctrl0_q.duty_select != `DUTY_STOP && !watch_stop) |=> drive_switch_q)
        else $error("drive switch off while running");

    divider_follow_a: assert property ( // [R19]
        @(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> divider_on_q == $past(ctrl0_q.divider_connect))
        else $error("divider not connected");

    dedicated_segs_a: assert property ( // [R7]
        @(posedge ref_clk) disable iff (!rstn)
        seg_en_q[7:0] == 8'hff && port_in_en_q[7:0] == 8'h00)
        else $error("dedicated segment pin released");

    group_select_a: assert property ( // [R8]
        @(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> seg_en_q[11:8] == {4{$past(ctrl1_q[0])}}
                 && seg_en_q[31:28] == {4{$past(ctrl1_q[5])}})
        else $error("segment group select mismatch");

    blank_unlit_a: assert property ( // [R21]
        @(posedge ref_clk) disable iff (!rstn)
        ctrl0_q.blank_select && run_c && $stable(ctrl1_q) |=> !any_seg_rail)
        else $error("segment lit while blanked");

    slot_ascend_a: assert property ( // [R24]
        @(posedge ref_clk) disable iff (!rstn)
        run_c && slot_tick && slot_q < last_slot ##1 run_c
        |-> slot_q == $past(slot_q) + 2'h1 && pol_q == $past(pol_q))
        else $error("slot did not advance by one");

    frame_toggle_a: assert property ( // [R10]
        @(posedge ref_clk) disable iff (!rstn)
        run_c && slot_tick && slot_q == last_slot ##1 run_c
        |-> slot_q == 2'h0 && pol_q != $past(pol_q))
        else $error("polarity did not alternate at frame end");

    unused_common_a: assert property ( // [R11]
        @(posedge ref_clk) disable iff (!rstn)
        run_c && ctrl0_q.duty_select == `DUTY_HALF && com_en_q[3:2] == 2'h3
        |=> !is_rail(com_level_q[2]) && !is_rail(com_level_q[3]))
        else $error("unused common not at non-selected level");

    ram_write_a: assert property ( // [R4]
        @(posedge ref_clk) disable iff (!rstn)
        req.wr && req.addr <= `ADDR_RAM_LAST ##1 req.rd && req.addr == $past(req.addr)
        |=> rdata_q == $past(req.wdata, 2))
        else $error("display RAM readback mismatch");

endmodule
`default_nettype wire

// ==== test/lcd_panel_model.sv ====
`default_nettype none
module lcd_panel_model (
    input  wire logic [3:0][1:0]  com_level, // common drive codes
    input  wire logic [31:0][1:0] seg_level, // segment drive codes
    input  wire logic [3:0]       com_en,    // common wired to glass
    input  wire logic [31:0]      seg_en,    // segment wired to glass
    output logic [31:0]           lit        // some element on this segment is on
);
    timeunit 1ns;
    timeprecision 1ps;

    // an element only turns on across the full V3 to V0 span, either polarity;
    // a pin in port use is not part of the glass
    always_comb
    begin
        lit = '0;
        for (int s = 0; s < 32; s++)
        begin
            for (int c = 0; c < 4; c++)
            begin
                if (com_en[c] && seg_en[s] &&
                    ({com_level[c], seg_level[s]} == 4'h3 ||
                     {com_level[c], seg_level[s]} == 4'hc))
                    lit[s] = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/lcd_segment_common_driver_test.sv ====
`include "lcd_defs.svh"
`default_nettype none
module lcd_segment_common_driver_test;
    timeunit 1ns;
    timeprecision 1ps;
    import lcd_pkg::*;

    logic             ref_clk = 1'b0;
    logic             rstn = 1'b0;
    reg_req_s         req = '0;
    logic [7:0]       rdata_q;
    logic             main_clk_pin = 1'b0;
    logic             sub_clk_pin = 1'b0;
    logic             watch_mode_select = 1'b1;
    logic [3:0][1:0]  com_level_q;
    logic [31:0][1:0] seg_level_q;
    logic [3:0]       com_en_q;
    logic [31:0]      seg_en_q;
    logic [31:0]      port_in_en_q;
    logic             drive_switch_q;
    logic             divider_on_q;
    logic [31:0]      lit;
    int               n_mismatch = 0;
    int               check_count = 0;

    always #12.5 ref_clk = ~ref_clk;

    lcd_segment_common_driver #(.RAM_BYTES(16)) u_lcd_segment_common_driver (
        .ref_clk(ref_clk), .rstn(rstn), .req(req), .rdata_q(rdata_q),
        .main_clk_pin(main_clk_pin), .sub_clk_pin(sub_clk_pin),
        .watch_mode_select(watch_mode_select), .com_level_q(com_level_q),
        .seg_level_q(seg_level_q), .com_en_q(com_en_q), .seg_en_q(seg_en_q),
        .port_in_en_q(port_in_en_q), .drive_switch_q(drive_switch_q),
        .divider_on_q(divider_on_q));

    lcd_panel_model u_lcd_panel_model (
        .com_level(com_level_q), .seg_level(seg_level_q), .com_en(com_en_q),
        .seg_en(seg_en_q), .lit(lit));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask

    // read data only stand in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        req.rd   <= 1'b1;
        req.addr <= a;
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 d = rdata_q;
    endtask

    // write and read of one address back to back, no idle cycle between
    task automatic wr_rd(input logic [4:0] a, input logic [7:0] v, output logic [7:0] d);
        @(posedge ref_clk);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= v;
        @(posedge ref_clk);
        req.wr <= 1'b0;
        req.rd <= 1'b1;
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 d = rdata_q;
    endtask

    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // one frame clock edge is one slot; sync plus edge flop plus level flop
    task automatic tick(input logic sub);
        @(posedge ref_clk);
        if (sub)
            sub_clk_pin <= 1'b1;
        else
            main_clk_pin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sub_clk_pin  <= 1'b0;
        main_clk_pin <= 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
    endtask

    function automatic logic [1:0] com_exp(int c, int slot, logic pol);
        if (c == slot)
            return pol ? `LV0 : `LV3;
        return pol ? `LV2 : `LV1;
    endfunction

    function automatic logic [1:0] seg_exp(logic on, logic pol);
        if (on)
            return pol ? `LV3 : `LV0;
        return pol ? `LV1 : `LV2;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check(seg_en_q, 32'h000000ff);
        check(port_in_en_q, 32'hffffff00);
        check({28'h0, com_en_q}, 32'h0);
        check({24'h0, com_level_q}, 32'h0);
        check(seg_level_q[15:0], 32'h0);
        check({30'h0, drive_switch_q, divider_on_q}, 32'h0);
    endtask

    // all upper pins are still port pins here
    task automatic t_ram();
        logic [7:0] d;
        for (int i = 0; i < 16; i++)
            wr(5'(i), 8'h3c ^ 8'(i * 17));
        for (int i = 0; i < 16; i++)
        begin
            rd(5'(i), d);
            check(d, 8'h3c ^ 8'(i * 17));
        end
        wr_rd(5'h07, 8'ha5, d);
        check(d, 8'ha5);
        rd(5'h14, d);
        check(d, 8'h00);
    endtask

    task automatic t_pins();
        logic [7:0] d;
        for (int g = 0; g < 6; g++)
        begin
            wr(`ADDR_CONTROL_1, 8'(1 << g));
            settle();
            check(seg_en_q, 32'hff | (32'hf << (8 + 4 * g)));
            check(port_in_en_q, ~(32'hff | (32'hf << (8 + 4 * g))));
        end
        wr(`ADDR_CONTROL_1, 8'hff);
        wr(`ADDR_COMMON_SEL, 8'hff);
        settle();
        check(port_in_en_q, 32'h0);
        check({28'h0, com_en_q}, 32'hf);
        rd(`ADDR_CONTROL_1, d);
        check(d, 8'h3f);
    endtask

    // two frames; the byte is rewritten at the frame boundary
    task automatic t_scan(input logic [1:0] duty, input logic blank);
        logic [7:0] b;
        logic [7:0] d;
        int         n;
        b = 8'h5a;
        n = duty + 1;
        wr(5'h00, b);
        wr(`ADDR_CONTROL_0, 8'h20);
        settle();
        check({30'h0, drive_switch_q, divider_on_q}, 32'h1);
        check({24'h0, com_level_q}, 32'h0);
        check(seg_level_q[15:0], 32'h0);
        wr(`ADDR_CONTROL_0, {3'b001, blank, duty, 2'b00});
        settle();
        check({31'h0, drive_switch_q}, 32'h1);
        for (int k = 0; k < 2 * n; k++)
        begin
            if (k == n)
            begin
                b = 8'hc3;
                wr(5'h00, b);
                settle();
            end
            for (int c = 0; c < 4; c++)
                check(com_level_q[c], com_exp(c, k % n, k >= n));
            check(seg_level_q[0], seg_exp(b[k % n] & !blank, k >= n));
            check(seg_level_q[1], seg_exp(b[4 + k % n] & !blank, k >= n));
            check(lit[1:0], {b[4 + k % n], b[k % n]} & {2{!blank}});
            rd(`ADDR_STATUS, d);
            check(d, {5'b00001, k >= n, 2'(k % n)});
            tick(1'b0);
        end
    endtask

    task automatic t_clock();
        logic [7:0] d;
        wr(`ADDR_CONTROL_0, 8'h20);
        wr(`ADDR_CONTROL_0, 8'h3c);
        // blanked first so the switch itself cannot flicker
        wr(`ADDR_CONTROL_0, 8'hbc);
        settle();
        tick(1'b0);
        rd(`ADDR_STATUS, d);
        check(d[1:0], 2'h0);
        tick(1'b1);
        rd(`ADDR_STATUS, d);
        check(d[1:0], 2'h1);
        @(posedge ref_clk);
        watch_mode_select <= 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        check({31'h0, drive_switch_q}, 32'h0);
        check({24'h0, com_level_q}, 32'h0);
        wr(`ADDR_CONTROL_0, 8'hfc);
        settle();
        check({31'h0, drive_switch_q}, 32'h1);
        rd(`ADDR_STATUS, d);
        check(d[4:3], 2'h3);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        close_out();
    end

    initial
    begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
        t_reset();
        t_ram();
        t_pins();
        t_scan(2'h1, 1'b0);
        t_scan(2'h2, 1'b0);
        t_scan(2'h3, 1'b0);
        t_scan(2'h3, 1'b1);
        t_clock();
        close_out();
    end
endmodule
`default_nettype wire
